// [design/sar_adc_channel_sequencer.sv]
// Channel sequencer and APB register file around a 12-bit SAR converter
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Results are 12 bits and conversion starts never come faster than 806 ksamples per second.
// - Eight channels are enabled by default and the scan extends to sixteen channels.
// - A started scan walks every enabled channel with no idle cycle between channels.
// - Channel choice comes either from the state machine or from a firmware-written channel field.
// - Each channel keeps its own latest result for software to read.
// - Each channel has its own programmed sample time, used whenever that channel samples.
// - Software programs a low and a high limit forming the accepted result window.
// - A result outside the window raises the out-of-range interrupt at once, mid-scan.
// - The reference is selectable among supply, half supply, band-gap or an external pin.
// - The sample-and-hold aperture length is programmable to give slow drivers settling time.
// - The on-chip temperature sensor can be selected as a conversion input.
// - Nothing runs while the chip is in deep sleep or hibernate.
// - The sequencer can own the amplifier routing switches instead of firmware.
module sar_adc_channel_sequencer (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic conv_done_in,
  input wire logic [11:0] conv_data_in,
  input wire logic lp_mode_in,
  output logic sample_out,
  output logic conv_start_out,
  output logic [4:0] mux_sel_out,
  output logic [1:0] ref_sel_out,
  output logic temp_bias_out,
  output logic [3:0] amp_switch_out,
  output logic busy_out,
  output logic irq_out
);
  // Software-visible state
  logic [11:0] ctrl;
  logic start_req;
  logic [15:0] ch_en;
  logic [11:0] lim_lo;
  logic [11:0] lim_hi;
  logic [1:0] intr;
  logic [1:0] mask;
  logic [3:0] sw_pat;
  logic [9:0] stime [16];
  logic [11:0] result [16];

  // Sequencer state
  sar_seq_pkg::seq_state_e state;
  logic [3:0] cur;
  logic [9:0] samp_cnt;
  logic [7:0] rate_cnt;

  // Decoded fields and strobes
  logic en;
  logic cont;
  logic manual;
  logic temp_en;
  logic sw_own;
  logic [3:0] man_ch;
  logic running_ok;
  logic [4:0] first;
  logic [4:0] nxt;
  logic done_ok;
  logic go_on;
  logic samp_end;
  logic oor_hit;
  logic oor_evt;
  logic eos_evt;
  logic acc;
  logic wr;
  logic rd_phase;
  logic [3:0] idx;
  logic [1:0] clr;
  logic [31:0] rdata;

  assign en = ctrl[sar_seq_pkg::CTRL_EN];
  assign cont = ctrl[sar_seq_pkg::CTRL_CONT];
  assign manual = ctrl[sar_seq_pkg::CTRL_MAN];
  assign temp_en = ctrl[sar_seq_pkg::CTRL_TEMP];
  assign sw_own = ctrl[sar_seq_pkg::CTRL_SWOWN];
  assign man_ch = ctrl[sar_seq_pkg::CTRL_MCH +: 4];

  // Bus phases: one wait state, write lands on the pready edge
  assign acc = psel_in & penable_in;
  assign wr = acc & pready_out & pwrite_in & sar_seq_pkg::reg_hit(paddr_in);
  assign rd_phase = acc & ~pready_out;
  assign idx = paddr_in[5:2];
  assign clr = (wr && (paddr_in == sar_seq_pkg::A_INTR)) ? pwdata_in[1:0] : 2'h0;

  // Deep sleep or hibernate removes the fast clock, so hold everything idle
  assign running_ok = en & ~lp_mode_in;

  // Channel walk decisions
  assign first = sar_seq_pkg::next_enabled(ch_en, 5'h00);
  assign nxt = sar_seq_pkg::next_enabled(ch_en, {1'b0, cur} + 5'h01);
  assign done_ok = (state == sar_seq_pkg::ST_CONVERT) & conv_done_in;
  assign go_on = done_ok & ~manual & (nxt[4] | (cont & first[4]));
  // Aperture ends after stime+1 cycles; a rate stall only lengthens it
  assign samp_end = (state == sar_seq_pkg::ST_SAMPLE) && (samp_cnt >= stime[cur])
    && (rate_cnt >= sar_seq_pkg::RATE_GAP);

  // Window compare on the raw result, so the flag does not wait for the store
  sar_window_check u_window (
    .value_in(conv_data_in),
    .low_in(lim_lo),
    .high_in(lim_hi),
    .out_of_range_out(oor_hit)
  );
  assign oor_evt = done_ok & oor_hit;
  assign eos_evt = done_ok & (manual | ~nxt[4]);

  // Control register and one-shot start
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ctrl <= sar_seq_pkg::CTRL_RST;
      start_req <= 1'b0;
    end else begin
      start_req <= wr && (paddr_in == sar_seq_pkg::A_CTRL) && pwdata_in[sar_seq_pkg::CTRL_START];
      if (wr && (paddr_in == sar_seq_pkg::A_CTRL)) begin
        ctrl <= pwdata_in[11:0] & sar_seq_pkg::CTRL_WMASK;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ch_en <= sar_seq_pkg::CH_EN_RST;
      lim_lo <= sar_seq_pkg::LIM_LO_RST;
      lim_hi <= sar_seq_pkg::LIM_HI_RST;
      mask <= 2'h0;
      sw_pat <= 4'h0;
    end else if (wr) begin
      case (paddr_in)
        sar_seq_pkg::A_CH_EN: ch_en <= pwdata_in[15:0];
        sar_seq_pkg::A_LIM_LO: lim_lo <= pwdata_in[11:0];
        sar_seq_pkg::A_LIM_HI: lim_hi <= pwdata_in[11:0];
        sar_seq_pkg::A_MASK: mask <= pwdata_in[1:0];
        sar_seq_pkg::A_SWITCH: sw_pat <= pwdata_in[3:0];
        default: ;
      endcase
    end
  end

  // Per-channel sample times
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < sar_seq_pkg::NUM_CH; i++) begin
        stime[i] <= sar_seq_pkg::STIME_RST;
      end
    end else if (wr && (paddr_in[7:6] == sar_seq_pkg::A_STIME[7:6])) begin
      stime[idx] <= pwdata_in[9:0];
    end
  end

  // Per-channel result buffers, written as each conversion lands
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < sar_seq_pkg::NUM_CH; i++) begin
        result[i] <= 12'h000;
      end
    end else if (done_ok) begin
      result[cur] <= conv_data_in;
    end
  end

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      intr <= 2'h0;
    end else begin
      intr <= (intr & ~clr) | {oor_evt, eos_evt};
    end
  end

  // Sequencer state machine
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state <= sar_seq_pkg::ST_IDLE;
      cur <= 4'h0;
      sample_out <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      if (!running_ok) begin
        state <= sar_seq_pkg::ST_IDLE;
        sample_out <= 1'b0;
      end else begin
        case (state)
          sar_seq_pkg::ST_IDLE: begin
            if (start_req && manual) begin
              cur <= man_ch;
              state <= sar_seq_pkg::ST_SAMPLE;
              sample_out <= 1'b1;
            end else if (start_req && first[4]) begin
              cur <= first[3:0];
              state <= sar_seq_pkg::ST_SAMPLE;
              sample_out <= 1'b1;
            end
          end
          sar_seq_pkg::ST_SAMPLE: begin
            if (samp_end) begin
              sample_out <= 1'b0;
              conv_start_out <= 1'b1;
              state <= sar_seq_pkg::ST_CONVERT;
            end
          end
          sar_seq_pkg::ST_CONVERT: begin
            if (go_on) begin
              // Next channel starts sampling on the very edge its predecessor lands
              cur <= nxt[4] ? nxt[3:0] : first[3:0];
              state <= sar_seq_pkg::ST_SAMPLE;
              sample_out <= 1'b1;
            end else if (done_ok) begin
              state <= sar_seq_pkg::ST_IDLE;
            end
          end
          default: begin
            state <= sar_seq_pkg::ST_IDLE;
            sample_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Aperture counter, cleared on every sample entry
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      samp_cnt <= 10'h000;
    end else if ((state != sar_seq_pkg::ST_SAMPLE) || samp_end || !running_ok) begin
      samp_cnt <= 10'h000;
    end else if (samp_cnt != 10'h3FF) begin
      samp_cnt <= samp_cnt + 10'h001;
    end
  end

  // Spacing since the last start, saturating so idle time counts as ready
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rate_cnt <= sar_seq_pkg::RATE_RST;
    end else if (samp_end && running_ok) begin
      rate_cnt <= 8'h00;
    end else if (rate_cnt != 8'hFF) begin
      rate_cnt <= rate_cnt + 8'h01;
    end
  end

  // Analog side controls, all registered
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      mux_sel_out <= 5'h00;
      ref_sel_out <= sar_seq_pkg::REF_VDD;
      temp_bias_out <= 1'b0;
      amp_switch_out <= 4'h0;
      busy_out <= 1'b0;
    end else begin
      if (manual) begin
        mux_sel_out <= {1'b0, man_ch};
      end else if (temp_en && (cur == 4'hF)) begin
        mux_sel_out <= sar_seq_pkg::MUX_TEMP;
      end else begin
        mux_sel_out <= {1'b0, cur};
      end
      ref_sel_out <= ctrl[sar_seq_pkg::CTRL_REF +: 2];
      // Bias is only spent while the sensor could be sampled
      temp_bias_out <= temp_en & running_ok;
      // Owned switches close only while a scan runs, in step with busy
      if (sw_own) begin
        amp_switch_out <= (state != sar_seq_pkg::ST_IDLE) ? sw_pat : 4'h0;
      end else begin
        amp_switch_out <= sw_pat;
      end
      busy_out <= state != sar_seq_pkg::ST_IDLE;
    end
  end

  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (paddr_in[7:6] == sar_seq_pkg::A_STIME[7:6]) begin
      rdata[9:0] = stime[idx];
    end else if (paddr_in[7:6] == sar_seq_pkg::A_RESULT[7:6]) begin
      rdata[11:0] = result[idx];
    end else begin
      case (paddr_in)
        sar_seq_pkg::A_CTRL: rdata[11:0] = ctrl;
        sar_seq_pkg::A_CH_EN: rdata[15:0] = ch_en;
        sar_seq_pkg::A_LIM_LO: rdata[11:0] = lim_lo;
        sar_seq_pkg::A_LIM_HI: rdata[11:0] = lim_hi;
        sar_seq_pkg::A_STATUS: begin
          rdata[sar_seq_pkg::STAT_BUSY] = state != sar_seq_pkg::ST_IDLE;
          rdata[sar_seq_pkg::STAT_STATE +: 2] = state;
          rdata[sar_seq_pkg::STAT_CUR +: 4] = cur;
        end
        sar_seq_pkg::A_INTR: rdata[1:0] = intr;
        sar_seq_pkg::A_MASK: rdata[1:0] = mask;
        sar_seq_pkg::A_SWITCH: rdata[3:0] = sw_pat;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer and interrupt line
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      pready_out <= rd_phase;
      prdata_out <= (rd_phase && !pwrite_in && sar_seq_pkg::reg_hit(paddr_in)) ? rdata : 32'h0000_0000;
      pslverr_out <= rd_phase && !sar_seq_pkg::reg_hit(paddr_in);
      irq_out <= |(intr & mask);
    end
  end

  // Checking helpers
  logic [7:0] gap;
  logic [9:0] hi_cnt;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      gap <= 8'hFF;
      hi_cnt <= 10'h000;
    end else begin
      gap <= conv_start_out ? 8'h00 : ((gap == 8'hFF) ? gap : gap + 8'h01);
      hi_cnt <= sample_out ? ((hi_cnt == 10'h3FF) ? hi_cnt : hi_cnt + 10'h001) : 10'h000;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_rate;
    conv_start_out |-> gap >= sar_seq_pkg::RATE_GAP;
  endproperty
  a_rate: assert property (p_rate) else $error("conversion starts too close");

  property p_noidle;
    (state == sar_seq_pkg::ST_CONVERT) && conv_done_in && running_ok && !manual && nxt[4]
      |=> sample_out && (cur == $past(nxt[3:0]));
  endproperty
  a_noidle: assert property (p_noidle) else $error("idle gap between channels");

  property p_man;
    manual |=> mux_sel_out == {1'b0, $past(man_ch)};
  endproperty
  a_man: assert property (p_man) else $error("manual channel not on mux");

  property p_store;
    (state == sar_seq_pkg::ST_CONVERT) && conv_done_in |=> result[$past(cur)] == $past(conv_data_in);
  endproperty
  a_store: assert property (p_store) else $error("result not buffered");

  property p_samp;
    $fell(sample_out) && $past(running_ok) |-> $past(hi_cnt) >= stime[cur];
  endproperty
  a_samp: assert property (p_samp) else $error("aperture shorter than programmed");

  property p_oor;
    (state == sar_seq_pkg::ST_CONVERT) && conv_done_in && ((conv_data_in < lim_lo) || (conv_data_in > lim_hi))
      |=> intr[sar_seq_pkg::INT_OOR] ##1 (irq_out || !$past(mask[sar_seq_pkg::INT_OOR]));
  endproperty
  a_oor: assert property (p_oor) else $error("out of range not flagged");

  property p_ref;
    wr && (paddr_in == sar_seq_pkg::A_CTRL) |=> ##1 ref_sel_out == $past(pwdata_in[9:8], 2);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select not applied");

  property p_temp;
    !manual && temp_en && (cur == 4'hF) |=> mux_sel_out == sar_seq_pkg::MUX_TEMP;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature input not selected");

  property p_lp;
    lp_mode_in |=> (state == sar_seq_pkg::ST_IDLE) && !sample_out ##1 !busy_out;
  endproperty
  a_lp: assert property (p_lp) else $error("running in low power mode");

  property p_sw;
    sw_own && (state == sar_seq_pkg::ST_IDLE) |=> amp_switch_out == 4'h0;
  endproperty
  a_sw: assert property (p_sw) else $error("owned switches closed while idle");

  property p_eos;
    (state == sar_seq_pkg::ST_CONVERT) && conv_done_in && !cont && !nxt[4]
      |=> (state == sar_seq_pkg::ST_IDLE) && intr[sar_seq_pkg::INT_EOS];
  endproperty
  a_eos: assert property (p_eos) else $error("scan end not flagged");

  c_eos: cover property (eos_evt && !manual);
  c_oor: cover property (oor_evt ##1 irq_out);
  c_wrap: cover property (go_on && cont && !nxt[4]);
  c_manual: cover property (done_ok && manual);
endmodule // sar_adc_channel_sequencer

// [design/sar_seq_pkg.sv]
// Shared constants, register map and helpers for the SAR channel sequencer
package sar_seq_pkg;
  // Converter and channel geometry
  localparam int NUM_CH = 16;
  localparam int RES_W = 12;
  localparam int STIME_W = 10;
  localparam logic [15:0] CH_EN_RST = 16'h00FF;
  localparam logic [4:0] MUX_TEMP = 5'h10;

  // Conversion rate ceiling, turned into a least spacing of starts
  localparam int CLK_HZ = 100_000_000;
  localparam int MAX_SPS = 806_000;
  localparam int MIN_CONV_CYC = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
  localparam logic [7:0] RATE_GAP = 8'(MIN_CONV_CYC - 1);

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CH_EN = 8'h04;
  localparam logic [7:0] A_LIM_LO = 8'h08;
  localparam logic [7:0] A_LIM_HI = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_INTR = 8'h14;
  localparam logic [7:0] A_MASK = 8'h18;
  localparam logic [7:0] A_SWITCH = 8'h1C;
  localparam logic [7:0] A_CFG_END = 8'h20;
  localparam logic [7:0] A_STIME = 8'h40;
  localparam logic [7:0] A_RESULT = 8'h80;
  localparam logic [7:0] A_MAP_END = 8'hC0;

  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_MAN = 3;
  localparam int CTRL_MCH = 4;
  localparam int CTRL_REF = 8;
  localparam int CTRL_TEMP = 10;
  localparam int CTRL_SWOWN = 11;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [11:0] CTRL_WMASK = 12'hFFD;

  // Status and interrupt fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_STATE = 1;
  localparam int STAT_CUR = 4;
  localparam int INT_EOS = 0;
  localparam int INT_OOR = 1;

  // Other reset values
  localparam logic [11:0] LIM_LO_RST = 12'h000;
  localparam logic [11:0] LIM_HI_RST = 12'hFFF;
  localparam logic [9:0] STIME_RST = 10'h003;
  localparam logic [7:0] RATE_RST = 8'hFF;

  typedef enum logic [1:0] {
    REF_VDD = 2'h0,
    REF_HALF_VDD = 2'h1,
    REF_BANDGAP = 2'h2,
    REF_EXTERNAL = 2'h3
  } ref_sel_e;

  // Gray along idle, sample, convert, sample
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } seq_state_e;

  // Lowest enabled channel at or above from; bit 4 says one was found
  function automatic logic [4:0] next_enabled(input logic [15:0] en, input logic [4:0] from);
    logic [4:0] hit;
    hit = 5'h00;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (en[i] && (5'(i) >= from)) begin
        hit = {1'b1, 4'(i)};
      end
    end
    return hit;
  endfunction

  // Aligned and mapped register address
  function automatic logic reg_hit(input logic [7:0] a);
    return (a[1:0] == 2'h0) && ((a < A_CFG_END) || ((a >= A_STIME) && (a < A_MAP_END)));
  endfunction
endpackage

// [design/sar_window_check.sv]
// Range window comparator for conversion results
`timescale 1ns/1ps
module sar_window_check (
  input wire logic [11:0] value_in,
  input wire logic [11:0] low_in,
  input wire logic [11:0] high_in,
  output logic out_of_range_out
);
  // Limits are inclusive; a swapped pair flags every result
  always_comb begin
    out_of_range_out = (value_in < low_in) || (value_in > high_in);
  end
endmodule // sar_window_check

// [test/conv_model.sv]
// Behavioural model of the converter core seen from the sequencer
`timescale 1ns/1ps
module conv_model #(
  parameter int LAT = 110
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic conv_start_in,
  input wire logic [4:0] mux_sel_in,
  output logic conv_done_out,
  output logic [11:0] conv_data_out
);
  int cnt;
  logic [4:0] held;

  // Fixed latency, shorter than the start spacing, so the rate stall shows up
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt <= 0;
      held <= 5'h00;
      conv_done_out <= 1'b0;
      conv_data_out <= 12'h000;
    end else begin
      if (conv_start_in) begin
        cnt <= LAT;
        held <= mux_sel_in;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      conv_done_out <= (cnt == 1);
      if (cnt == 1) begin
        conv_data_out <= (held == 5'h10) ? 12'hABC : {held[3:0], 8'h23};
      end else begin
        conv_data_out <= ~conv_data_out; // Data never stays valid outside the done pulse
      end
    end
  end
endmodule // conv_model

// [test/testbench.sv]
// Self-checking bench for the channel sequencer over APB
`timescale 1ns/1ps
module testbench;
  logic sys_clk_in, nrst_in, psel_in, penable_in, pwrite_in, lp_mode_in, err;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, rd;
  wire logic [31:0] prdata_out;
  wire logic pready_out, pslverr_out, conv_done_in, sample_out, conv_start_out;
  wire logic temp_bias_out, busy_out, irq_out;
  wire logic [11:0] conv_data_in;
  wire logic [4:0] mux_sel_out;
  wire logic [1:0] ref_sel_out;
  wire logic [3:0] amp_switch_out;
  int n_mismatch, check_count, slen, gap, len_by_mux[17];
  bit seen;
  logic [7:0] def_a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40, 8'h80};
  logic [31:0] def_v[6] = '{32'h0, 32'h00FF, 32'h0, 32'h0FFF, 32'h3, 32'h0};

  sar_adc_channel_sequencer i_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .lp_mode_in(lp_mode_in),
    .sample_out(sample_out), .conv_start_out(conv_start_out), .mux_sel_out(mux_sel_out),
    .ref_sel_out(ref_sel_out), .temp_bias_out(temp_bias_out), .amp_switch_out(amp_switch_out),
    .busy_out(busy_out), .irq_out(irq_out));

  conv_model i_conv (.clk_in(sys_clk_in), .nrst_in(nrst_in), .conv_start_in(conv_start_out),
    .mux_sel_in(mux_sel_out), .conv_done_out(conv_done_in), .conv_data_out(conv_data_in));

  // Free-running system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic fail(string m);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    check_count++;
    if (got !== exp) fail(m);
  endtask

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // Look just after each edge, once pready has settled
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      #1;
      if (pready_out === 1'b1) break;
    end
    if (i == 20) begin
      fail("bus timeout");
      give_verdict();
    end
    q = prdata_out;
    e = pslverr_out;
    // Completion edge, then release
    @(posedge sys_clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp, "read data");
    chk(32'(err), 32'h0, "unexpected bus error");
  endtask

  // Bounded wait: 0 done pulse, 1 idle, 2 sampling
  task automatic wait_for(int which);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge sys_clk_in);
      #1;
      if (which == 0 && conv_done_in === 1'b1) break;
      if (which == 1 && busy_out === 1'b0) break;
      if (which == 2 && sample_out === 1'b1) break;
    end
    if (i == 3000) begin
      fail("wait timeout");
      give_verdict();
    end
  endtask

  function automatic logic [31:0] exp_val(int ch);
    return (ch == 16) ? 32'h0ABC : 32'({4'(ch), 8'h23});
  endfunction

  // Sample window lengths per input and start spacing, read mid-cycle
  always @(negedge sys_clk_in) begin
    if (sample_out === 1'b1) begin
      slen++;
    end else if (slen != 0) begin
      if (mux_sel_out <= 5'h10) len_by_mux[mux_sel_out] = slen;
      slen = 0;
    end
    if (conv_start_out === 1'b1) begin
      check_count++;
      if (seen && gap < sar_seq_pkg::MIN_CONV_CYC - 1) fail("conversion starts too close");
      gap = 0;
      seen = 1'b1;
    end else begin
      gap++;
    end
  end

  // Main sequence
  initial begin
    {psel_in, penable_in, pwrite_in, lp_mode_in, nrst_in} = 5'h00;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    repeat (10) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    for (int k = 0; k < 6; k++) rdchk(def_a[k], def_v[k]);
    apb(1'b0, 8'h20, 32'h0, rd, err);
    chk(32'(err), 32'h1, "no error on unmapped address");
    chk(rd, 32'h0, "unmapped read not zero");
    // Three-channel scan: below, inside and above the window
    wr(sar_seq_pkg::A_CH_EN, 32'h7);
    wr(sar_seq_pkg::A_STIME + 8'h04, 32'h7);
    wr(sar_seq_pkg::A_STIME + 8'h08, 32'h14);
    wr(sar_seq_pkg::A_LIM_LO, 32'h050);
    wr(sar_seq_pkg::A_LIM_HI, 32'h1FF);
    wr(sar_seq_pkg::A_MASK, 32'h3);
    wr(sar_seq_pkg::A_CTRL, 32'h3);
    wait_for(0);
    @(posedge sys_clk_in);
    #1 chk(32'(sample_out), 32'h1, "idle gap before next channel");
    repeat (2) @(posedge sys_clk_in);
    #1 chk(32'(irq_out), 32'h1, "no interrupt mid-scan");
    chk(32'(busy_out), 32'h1, "scan ended early");
    rdchk(sar_seq_pkg::A_INTR, 32'h2);
    wait_for(1);
    rdchk(sar_seq_pkg::A_INTR, 32'h3);
    for (int ch = 0; ch < 3; ch++) rdchk(sar_seq_pkg::A_RESULT + 8'(4 * ch), exp_val(ch));
    chk(32'(len_by_mux[0]), 32'd4, "sample length ch0");
    // Channel 1 waits out the start spacing: model latency 110 plus two register stages
    chk(32'(len_by_mux[1]), 32'(sar_seq_pkg::MIN_CONV_CYC - 112), "rate stall ch1");
    chk(32'(len_by_mux[2]), 32'd21, "sample length ch2");
    wr(sar_seq_pkg::A_MASK, 32'h0);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(32'(irq_out), 32'h0, "masked interrupt still high");
    wr(sar_seq_pkg::A_INTR, 32'h3);
    rdchk(sar_seq_pkg::A_INTR, 32'h0);
    // Every reference choice
    for (int r = 0; r < 4; r++) begin
      wr(sar_seq_pkg::A_CTRL, 32'(r) << 8);
      repeat (2) @(posedge sys_clk_in);
      #1 chk(32'(ref_sel_out), 32'(r), "reference select");
    end
    // Firmware-chosen channel 5
    wr(sar_seq_pkg::A_CTRL, 32'h5B);
    wait_for(2);
    #1 chk(32'(mux_sel_out), 32'h5, "manual channel");
    wait_for(1);
    rdchk(sar_seq_pkg::A_RESULT + 8'h14, exp_val(5));
    // Temperature sensor in place of channel 15
    wr(sar_seq_pkg::A_CH_EN, 32'h8000);
    wr(sar_seq_pkg::A_CTRL, 32'h403);
    wait_for(2);
    @(posedge sys_clk_in);
    #1 chk(32'(mux_sel_out), 32'h10, "temperature input");
    chk(32'(temp_bias_out), 32'h1, "sensor bias off");
    wait_for(1);
    rdchk(sar_seq_pkg::A_RESULT + 8'h3C, exp_val(16));
    // Routing switches, firmware-owned then sequencer-owned
    wr(sar_seq_pkg::A_SWITCH, 32'hA);
    wr(sar_seq_pkg::A_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(32'(amp_switch_out), 32'hA, "firmware switches");
    wr(sar_seq_pkg::A_CTRL, 32'h800);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(32'(amp_switch_out), 32'h0, "owned switches while idle");
    // Continuous scan of one channel, owning the switches
    wr(sar_seq_pkg::A_CTRL, 32'h807);
    wait_for(2);
    @(posedge sys_clk_in);
    #1 chk(32'(amp_switch_out), 32'hA, "owned switches while scanning");
    wait_for(0);
    wait_for(0);
    @(posedge sys_clk_in);
    #1 chk(32'(sample_out), 32'h1, "continuous scan did not wrap");
    // Low-power entry mid-sample, then a start while asleep
    @(posedge sys_clk_in);
    lp_mode_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    #1 chk(32'(busy_out), 32'h0, "still busy in low power");
    chk(32'(sample_out), 32'h0, "sampling in low power");
    wr(sar_seq_pkg::A_CTRL, 32'h3);
    repeat (4) @(posedge sys_clk_in);
    #1 chk(32'(sample_out), 32'h0, "started in low power");
    @(posedge sys_clk_in);
    lp_mode_in <= 1'b0;
    give_verdict();
  end
endmodule // testbench
